// File: design/debug_bkpt_compare.sv
// Registered comparator of the CPU address bus against the match address.
`timescale 1ns/100ps
module debug_bkpt_compare (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Compare inputs.
  input  wire logic        enable_i,
  input  wire logic [15:0] match_addr_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        cpu_access_i,
  input  wire logic        cpu_fetch_i,
  // One-cycle hit pulses.
  output logic             hit_o,
  output logic             fetch_hit_o
);

  typedef struct packed {
    logic hit;
    logic fetch_hit;
  } cmp_state_t;

  cmp_state_t s_r;
  cmp_state_t s_nxt;
  logic       same;

  // A disabled comparator never hits, whatever the match address holds.
  always_comb begin
    same            = enable_i && (cpu_addr_i == match_addr_i);
    s_nxt.hit       = same && cpu_access_i;
    s_nxt.fetch_hit = same && cpu_fetch_i;
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hit_o       = s_r.hit;
  assign fetch_hit_o = s_r.fetch_hit;

endmodule : debug_bkpt_compare

// File: design/debug_cmd_decode.sv
// Decoder from a serial command code to one strobe per register action.
`timescale 1ns/100ps
module debug_cmd_decode (
  // Command in.
  input  wire logic       valid_i,
  input  wire logic [7:0] code_i,
  // Decoded strobes.
  output logic            rd_status_o,
  output logic            wr_control_o,
  output logic            rd_match_o,
  output logic            wr_match_o,
  output logic            halt_o
);

  // Unknown codes raise no strobe; other blocks own the rest of the set.
  always_comb begin
    rd_status_o  = valid_i && (code_i == debug_regs_pkg::CMD_READ_STATUS);
    wr_control_o = valid_i && (code_i == debug_regs_pkg::CMD_WRITE_CONTROL);
    rd_match_o   = valid_i && (code_i == debug_regs_pkg::CMD_READ_MATCH);
    wr_match_o   = valid_i && (code_i == debug_regs_pkg::CMD_WRITE_MATCH);
    halt_o       = valid_i && (code_i == debug_regs_pkg::CMD_HALT);
  end

endmodule : debug_cmd_decode

// File: design/debug_regs_pkg.sv
// Constants, field layout and types of the serial debug register block.
package debug_regs_pkg;

  // Clock period of the block clock in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 25;

  // Register widths.
  localparam int unsigned STATUS_W = 8;
  localparam int unsigned MATCH_W  = 16;

  // Serial command codes handled by this block.
  localparam logic [7:0] CMD_READ_STATUS   = 8'hE4;
  localparam logic [7:0] CMD_WRITE_CONTROL = 8'hC4;
  localparam logic [7:0] CMD_READ_MATCH    = 8'hE2;
  localparam logic [7:0] CMD_WRITE_MATCH   = 8'hC2;
  localparam logic [7:0] CMD_HALT          = 8'h90;

  // Bit positions inside the status and control byte.
  localparam int unsigned BIT_PERMIT      = 7;
  localparam int unsigned BIT_HALT_ACTIVE = 6;
  localparam int unsigned BIT_BKPT_EN     = 5;
  localparam int unsigned BIT_FTS         = 4;
  localparam int unsigned BIT_CLK_SEL     = 3;
  localparam int unsigned BIT_WS          = 2;
  localparam int unsigned BIT_WSF         = 1;
  localparam int unsigned BIT_DVF         = 0;

  // Reset values.
  localparam logic          PERMIT_RESET  = 1'b0;
  localparam logic          BKPT_EN_RESET = 1'b0;
  localparam logic          FTS_RESET     = 1'b0;
  localparam logic          CLK_SEL_RESET = 1'b0;
  localparam logic [15:0]   MATCH_RESET   = 16'h0000;
  localparam logic          DVF_VALUE     = 1'b0;

  // Halt request sequencer, Gray coded along idle, armed, request.
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ARMED = 2'b01,
    SEQ_REQ   = 2'b11
  } halt_seq_t;

endpackage : debug_regs_pkg

// File: design/debug_status_breakpoint_regs.sv
// Status/control and breakpoint match registers of the serial debug unit.
`timescale 1ns/100ps
module debug_status_breakpoint_regs (
  // Clock and synchronous reset.
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,

  // Register commands from the serial link decoder.
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] cmd_wdata_i,

  // Register read answers back to the serial link.
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_data_o,

  // CPU address bus observation.
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        cpu_access_i,
  input  wire logic        cpu_fetch_i,
  input  wire logic        cpu_boundary_i,
  input  wire logic        cpu_tag_exec_i,

  // CPU mode reporting.
  input  wire logic        cpu_in_halt_i,
  input  wire logic        cpu_wait_stop_i,
  input  wire logic        mem_cmd_start_i,
  input  wire logic        mem_ws_fail_i,

  // Halt and tag requests to the CPU.
  output logic             halt_req_o,
  output logic             tag_o,

  // Communication clock selection.
  input  wire logic        alt_tick_i,
  output logic             comm_clock_select_o,
  output logic             comm_tick_o,

  // Control bits seen by the rest of the debug logic.
  output logic             halt_mode_permit_o,
  output logic             breakpoint_enable_o
);

  // Command timing. A register command is one cycle of cmd_valid_i with
  // its code and data, taken on that rising edge. Its effect is seen by
  // a command issued in the very next cycle, so the host may send
  // commands back to back. Reads answer with a one-cycle pulse on
  // rsp_valid_o one edge after the command. Writes and the halt command
  // give no answer, so a refused write is silent and the host must read
  // the status byte back to learn what was kept.

  // Breakpoint timing. The comparator registers its hit, so a forced
  // breakpoint asks for halt two edges after the matching access at the
  // earliest, and a tag pulse leaves two edges after the fetch. That is
  // one cycle more than a purely combinational compare; the trade buys
  // a short path from the CPU address bus.

  // Every input is already on the block clock, so nothing is
  // synchronised; the alternate tick arrives as a one-cycle enable.

  // Complete state of the block.
  typedef struct packed {
    logic                      halt_mode_permit;
    logic                      breakpoint_enable_bit;
    logic                      force_or_tag_select;
    logic                      comm_clock_select;
    logic                      halt_active_flag;
    logic                      woken_from_wait;
    logic                      wait_stop_flag;
    logic                      wait_stop_failure_flag;
    logic [15:0]               breakpoint_match_address;
    debug_regs_pkg::halt_seq_t seq;
    logic                      halt_req;
    logic                      tag;
    logic                      rsp_valid;
    logic [15:0]               rsp_data;
    logic                      comm_tick;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // Decoded command strobes.
  logic rd_status;
  logic wr_control;
  logic rd_match;
  logic wr_match;
  logic halt_cmd;

  // Comparator hit pulses.
  logic addr_hit;
  logic fetch_hit;

  // Status byte as the host sees it.
  logic [7:0] status_byte;

  // Conditions used by the sequencer, the tag pulse and the wake-up flag.
  logic force_hit;
  logic tag_hit;
  logic halt_accept;
  logic leaving_halt;

  // Codes outside this block's share of the command set raise no strobe,
  // so the other command handlers can share the same code bus.
  // The registers have no memory address: only these strobes reach them.
  debug_cmd_decode u_decode (
    .valid_i      (cmd_valid_i),
    .code_i       (cmd_code_i),
    .rd_status_o  (rd_status),
    .wr_control_o (wr_control),
    .rd_match_o   (rd_match),
    .wr_match_o   (wr_match),
    .halt_o       (halt_cmd)
  );

  // The enable comes from the register, not from the write data, so a
  // breakpoint written in one command is armed from the next cycle on.
  // Address comparator, gated by the breakpoint enable bit.
  debug_bkpt_compare u_compare (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .enable_i     (s_r.breakpoint_enable_bit),
    .match_addr_i (s_r.breakpoint_match_address),
    .cpu_addr_i   (cpu_addr_i),
    .cpu_access_i (cpu_access_i),
    .cpu_fetch_i  (cpu_fetch_i),
    .hit_o        (addr_hit),
    .fetch_hit_o  (fetch_hit)
  );

  // The byte is rebuilt every cycle from the live flags, so a read
  // reports the state of the cycle in which the command is taken. Bit
  // positions come from the package so that the write path and the
  // read path cannot disagree on the layout.
  // Status byte assembly; the unused data-valid bit is a constant zero.
  always_comb begin
    status_byte = 8'h00;
    status_byte[debug_regs_pkg::BIT_PERMIT]      = s_r.halt_mode_permit;
    status_byte[debug_regs_pkg::BIT_HALT_ACTIVE] = s_r.halt_active_flag;
    status_byte[debug_regs_pkg::BIT_BKPT_EN]     = s_r.breakpoint_enable_bit;
    status_byte[debug_regs_pkg::BIT_FTS]         = s_r.force_or_tag_select;
    status_byte[debug_regs_pkg::BIT_CLK_SEL]     = s_r.comm_clock_select;
    status_byte[debug_regs_pkg::BIT_WS]          = s_r.wait_stop_flag;
    status_byte[debug_regs_pkg::BIT_WSF]     = s_r.wait_stop_failure_flag;
    status_byte[debug_regs_pkg::BIT_DVF]     = debug_regs_pkg::DVF_VALUE;
  end

  // Breakpoint qualifiers. The comparator already drops hits while the
  // enable is low, but the enable bit is also masked here so that a stale
  // tag or force decision cannot leak out after software disables it.
  always_comb begin
    force_hit = addr_hit && s_r.breakpoint_enable_bit &&
                s_r.force_or_tag_select;
    tag_hit   = fetch_hit && s_r.breakpoint_enable_bit &&
                !s_r.force_or_tag_select;
    // The halt command is taken even while the CPU sleeps, because it is
    // the only way out of wait or stop for the host.
    halt_accept  = halt_cmd && s_r.halt_mode_permit &&
                   !s_r.halt_active_flag;
    leaving_halt = s_r.halt_active_flag && !cpu_in_halt_i;
  end

  // Everything below starts from the held state, so a field that no
  // branch touches keeps its value. The status flags change only
  // through their sources and are never taken from write data,
  // which is what keeps them read-only to the host.
  // Next-state logic of the whole block.
  always_comb begin
    s_nxt = s_r;

    // Halt-active is the CPU's own report, one register stage later.
    s_nxt.halt_active_flag = cpu_in_halt_i;

    // The permit bit is locked while halted so that the host cannot
    // forbid a mode that is already active; the other bits of the same
    // byte are still written.
    // Control writes. Only the four control bits are taken from the data
    // byte; the status positions keep their hardware values.
    if (wr_control) begin
      if (!s_r.halt_active_flag) begin
        s_nxt.halt_mode_permit =
          cmd_wdata_i[debug_regs_pkg::BIT_PERMIT];
      end
      s_nxt.breakpoint_enable_bit =
        cmd_wdata_i[debug_regs_pkg::BIT_BKPT_EN];
      s_nxt.force_or_tag_select =
        cmd_wdata_i[debug_regs_pkg::BIT_FTS];
      s_nxt.comm_clock_select =
        cmd_wdata_i[debug_regs_pkg::BIT_CLK_SEL];
    end

    // The match register may be rewritten at any time, even while a
    // breakpoint is armed; the new address applies from the next cycle.
    // Hosts should change it while the target is halted, so that no hit
    // is taken on a half-changed setup.
    // Match register write takes the full 16-bit value.
    if (wr_match) begin
      s_nxt.breakpoint_match_address = cmd_wdata_i;
    end

    // Register commands keep working while the CPU sleeps; only memory
    // commands can fail then, and they fail in another block. The halt
    // command is the host's way out of a sleep.
    // Remember that a halt command pulled the CPU out of wait or stop, so
    // the host can tell a woken target from one halted while running.
    if (halt_accept && cpu_wait_stop_i) begin
      s_nxt.woken_from_wait = 1'b1;
    end else if (leaving_halt) begin
      s_nxt.woken_from_wait = 1'b0;
    end

    // Wait/stop flag: live sleep state or the remembered wake-up.
    s_nxt.wait_stop_flag = cpu_wait_stop_i ||
                           s_nxt.woken_from_wait;

    // The failure flag records a memory command that lost against a wait
    // or stop instruction. Only the start of another memory command
    // clears it, so a status read still sees it however long the host
    // takes to look.
    // Failure flag: set wins over the clear that a new access brings.
    if (mem_ws_fail_i) begin
      s_nxt.wait_stop_failure_flag = 1'b1;
    end else if (mem_cmd_start_i) begin
      s_nxt.wait_stop_failure_flag = 1'b0;
    end

    // The answer data drop back to zero when no read is pending, so a
    // stale byte can never be taken for a new answer.
    // Read answers appear one cycle after the command strobe.
    s_nxt.rsp_valid = rd_status || rd_match;
    if (rd_status) begin
      s_nxt.rsp_data = {8'h00, status_byte};
    end else if (rd_match) begin
      s_nxt.rsp_data = s_r.breakpoint_match_address;
    end else begin
      s_nxt.rsp_data = 16'h0000;
    end

    // The CPU carries the tag along its instruction queue and reports on
    // cpu_tag_exec_i only if the opcode is executed, so a tagged opcode
    // that is flushed never halts.
    // Tag pulse for a fetched opcode at the match address.
    s_nxt.tag = tag_hit;

    // The select bit may change at any time. The switch takes effect on
    // the next edge and can shorten one tick period; the host is
    // expected to resynchronise after changing the source.
    // Serial clock enable: every bus cycle, or the alternate source tick.
    s_nxt.comm_tick = s_r.comm_clock_select ? 1'b1 : alt_tick_i;

    // Forced breakpoint walk: the access is seen at edge c0 and the hit
    // registered at c1; a boundary at c1 raises the request at c2,
    // otherwise the sequencer waits armed and asks on the edge after
    // the boundary. The request stays high until the CPU reports halt,
    // as the CPU may need several cycles to finish its instruction. A
    // halt command or a tagged opcode at the end of the queue skips the
    // armed step and asks at once.
    // Limitation: a second hit while a request is pending is not queued;
    // it is lost, which is harmless as the CPU is about to halt anyway.
    // Halt request sequencer. With the permit low nothing may ask for
    // halt, so every path falls back to idle.
    s_nxt.halt_req = 1'b0;
    case (s_r.seq)
      debug_regs_pkg::SEQ_IDLE: begin
        if (!s_r.halt_mode_permit || s_r.halt_active_flag) begin
          s_nxt.seq = debug_regs_pkg::SEQ_IDLE;
        end else if (halt_accept || cpu_tag_exec_i) begin
          s_nxt.seq      = debug_regs_pkg::SEQ_REQ;
          s_nxt.halt_req = 1'b1;
        end else if (force_hit && cpu_boundary_i) begin
          s_nxt.seq      = debug_regs_pkg::SEQ_REQ;
          s_nxt.halt_req = 1'b1;
        end else if (force_hit) begin
          s_nxt.seq = debug_regs_pkg::SEQ_ARMED;
        end else begin
          s_nxt.seq = debug_regs_pkg::SEQ_IDLE;
        end
      end
      debug_regs_pkg::SEQ_ARMED: begin
        // A forced hit waits for the instruction in flight to finish;
        // disabling the breakpoint meanwhile cancels it.
        if (!s_r.halt_mode_permit || !s_r.breakpoint_enable_bit) begin
          s_nxt.seq = debug_regs_pkg::SEQ_IDLE;
        end else if (cpu_boundary_i || halt_accept || cpu_tag_exec_i) begin
          s_nxt.seq      = debug_regs_pkg::SEQ_REQ;
          s_nxt.halt_req = 1'b1;
        end else begin
          s_nxt.seq = debug_regs_pkg::SEQ_ARMED;
        end
      end
      debug_regs_pkg::SEQ_REQ: begin
        // Hold the request until the CPU reports halt.
        if (cpu_in_halt_i || !s_r.halt_mode_permit) begin
          s_nxt.seq = debug_regs_pkg::SEQ_IDLE;
        end else begin
          s_nxt.seq      = debug_regs_pkg::SEQ_REQ;
          s_nxt.halt_req = 1'b1;
        end
      end
      default: begin
        s_nxt.seq = debug_regs_pkg::SEQ_IDLE;
      end
    endcase
  end

  // Reset is synchronous and loads constants only. The halt-active flag
  // restarts at zero and follows the CPU one edge later, so a target
  // that stays halted through reset shows the flag again a cycle on.
  // Outputs read zero during reset and until the first edge after it.
  // State register; normal reset clears every control bit.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_r.halt_mode_permit         <= debug_regs_pkg::PERMIT_RESET;
      s_r.breakpoint_enable_bit    <= debug_regs_pkg::BKPT_EN_RESET;
      s_r.force_or_tag_select      <= debug_regs_pkg::FTS_RESET;
      s_r.comm_clock_select        <= debug_regs_pkg::CLK_SEL_RESET;
      s_r.halt_active_flag         <= 1'b0;
      s_r.woken_from_wait          <= 1'b0;
      s_r.wait_stop_flag           <= 1'b0;
      s_r.wait_stop_failure_flag   <= 1'b0;
      s_r.breakpoint_match_address <= debug_regs_pkg::MATCH_RESET;
      s_r.seq                      <= debug_regs_pkg::SEQ_IDLE;
      s_r.halt_req                 <= 1'b0;
      s_r.tag                      <= 1'b0;
      s_r.rsp_valid                <= 1'b0;
      s_r.rsp_data                 <= 16'h0000;
      s_r.comm_tick                <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output is a bare register bit: no logic stands between the
  // state register and a pin, so the far side sees clean levels and
  // the delay from clock to output is that of one flip-flop.
  // Outputs straight from the state register.
  assign rsp_valid_o         = s_r.rsp_valid;
  assign rsp_data_o          = s_r.rsp_data;
  assign halt_req_o          = s_r.halt_req;
  assign tag_o               = s_r.tag;
  assign comm_clock_select_o = s_r.comm_clock_select;
  assign comm_tick_o         = s_r.comm_tick;
  assign halt_mode_permit_o  = s_r.halt_mode_permit;
  assign breakpoint_enable_o = s_r.breakpoint_enable_bit;

endmodule : debug_status_breakpoint_regs

// File: tb/cpu_halt_model.sv
// Behavioural CPU that answers halt requests of the debug registers.
`timescale 1ns/100ps
module cpu_halt_model (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Halt handshake.
  input  wire logic halt_req_i,
  input  wire logic resume_i,
  output logic      in_halt_o
);
  // Halt is entered one cycle after a request and left only on resume, so
  // the block must hold its request until the halt is seen.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      in_halt_o <= 1'b0;
    end else if (resume_i) begin
      in_halt_o <= 1'b0;
    end else if (halt_req_i) begin
      in_halt_o <= 1'b1;
    end
  end
endmodule : cpu_halt_model

// File: tb/debug_regs_monitor.sv
// Port-level checker of the serial debug status and breakpoint registers.
`timescale 1ns/100ps
module debug_regs_monitor (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // Command side.
  input wire logic        cmd_valid_i,
  input wire logic [7:0]  cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic        rsp_valid_o,
  input wire logic [15:0] rsp_data_o,
  // CPU and control side.
  input wire logic        cpu_in_halt_i,
  input wire logic        halt_req_o,
  input wire logic        tag_o,
  input wire logic        alt_tick_i,
  input wire logic        comm_clock_select_o,
  input wire logic        comm_tick_o,
  input wire logic        halt_mode_permit_o,
  input wire logic        breakpoint_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // A match write, one idle cycle, then a match read of the same word.
  sequence match_wr_s;
    cmd_valid_i && cmd_code_i == debug_regs_pkg::CMD_WRITE_MATCH;
  endsequence
  sequence match_rd_s;
    cmd_valid_i && cmd_code_i == debug_regs_pkg::CMD_READ_MATCH;
  endsequence

  status_read_a: assert property (cmd_valid_i && cmd_code_i == 8'hE4 |=>
    rsp_valid_o && rsp_data_o[15:8] == 8'h00 && !rsp_data_o[0])
    else $error("status answer malformed");
  write_quiet_a: assert property (cmd_valid_i && (cmd_code_i == 8'hC4 ||
    cmd_code_i == 8'hC2) |=> !rsp_valid_o) else $error("write answered");
  match_back_a: assert property (match_wr_s ##1 !cmd_valid_i ##1 match_rd_s
    |=> rsp_data_o == $past(cmd_wdata_i, 3)) else $error("match readback");
  permit_lock_a: assert property (cmd_valid_i && cmd_code_i == 8'hC4 &&
    $past(cpu_in_halt_i) |=> $stable(halt_mode_permit_o))
    else $error("permit written while halted");
  halt_cmd_a: assert property (cmd_valid_i && cmd_code_i == 8'h90 &&
    halt_mode_permit_o && !cpu_in_halt_i && !$past(cpu_in_halt_i)
    |=> halt_req_o) else $error("halt command not honoured");
  permit_off_a: assert property ((!halt_mode_permit_o)[*2] |-> !halt_req_o)
    else $error("halt requested without permit");
  bkpt_off_a: assert property ((!breakpoint_enable_o)[*3] |-> !tag_o)
    else $error("tag while breakpoint disabled");
  tick_bus_a: assert property (comm_clock_select_o &&
    $past(comm_clock_select_o) |-> comm_tick_o) else $error("bus tick lost");
  tick_alt_a: assert property (!comm_clock_select_o &&
    !$past(comm_clock_select_o) |-> comm_tick_o == $past(alt_tick_i))
    else $error("alternate tick wrong");
endmodule : debug_regs_monitor

bind debug_status_breakpoint_regs debug_regs_monitor mon (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
  .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
  .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
  .cpu_in_halt_i(cpu_in_halt_i), .halt_req_o(halt_req_o), .tag_o(tag_o),
  .alt_tick_i(alt_tick_i), .comm_clock_select_o(comm_clock_select_o),
  .comm_tick_o(comm_tick_o), .halt_mode_permit_o(halt_mode_permit_o),
  .breakpoint_enable_o(breakpoint_enable_o)
);

// File: tb/debug_status_breakpoint_regs_bench.sv
// Self-checking bench of the debug status and breakpoint registers.
`timescale 1ns/100ps
module debug_status_breakpoint_regs_bench;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, cmd_valid_i = 1'b0;
  logic [7:0]  cmd_code_i = 8'h00;
  logic [15:0] cmd_wdata_i = 16'h0000, cpu_addr_i = 16'h0F0F, rsp_data_o;
  logic        cpu_access_i = 1'b0, cpu_fetch_i = 1'b0, cpu_boundary_i = 1'b0;
  logic        cpu_tag_exec_i = 1'b0, cpu_wait_stop_i = 1'b0, resume = 1'b0;
  logic        mem_cmd_start_i = 1'b0, mem_ws_fail_i = 1'b0, alt_tick_i = 1'b0;
  logic        tick_run = 1'b0, cpu_in_halt_i, rsp_valid_o, halt_req_o, tag_o;
  logic        comm_clock_select_o, comm_tick_o, permit, bken;
  int          miscompares = 0, comparisons = 0;

  // The clock and a free alternate tick that starts only after reset.
  always #(debug_regs_pkg::CLK_PERIOD_NS / 2.0) clk_i = ~clk_i;
  always @(posedge clk_i) alt_tick_i <= #2 tick_run && !alt_tick_i;

  debug_status_breakpoint_regs dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .cpu_addr_i(cpu_addr_i),
    .cpu_access_i(cpu_access_i), .cpu_fetch_i(cpu_fetch_i),
    .cpu_boundary_i(cpu_boundary_i), .cpu_tag_exec_i(cpu_tag_exec_i),
    .cpu_in_halt_i(cpu_in_halt_i), .cpu_wait_stop_i(cpu_wait_stop_i),
    .mem_cmd_start_i(mem_cmd_start_i), .mem_ws_fail_i(mem_ws_fail_i),
    .halt_req_o(halt_req_o), .tag_o(tag_o), .alt_tick_i(alt_tick_i),
    .comm_clock_select_o(comm_clock_select_o), .comm_tick_o(comm_tick_o),
    .halt_mode_permit_o(permit), .breakpoint_enable_o(bken));
  cpu_halt_model cpu (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .halt_req_i(halt_req_o), .resume_i(resume), .in_halt_o(cpu_in_halt_i));

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  // One command cycle; the answer of a read is registered by the next edge.
  task automatic issue(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_i); #2;
    cmd_valid_i = 1'b1; cmd_code_i = c; cmd_wdata_i = d;
    @(posedge clk_i); #2;
    cmd_valid_i = 1'b0;
  endtask : issue

  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    issue(c, 16'h0000);
    check("rsp_valid", {15'h0000, rsp_valid_o}, 16'h0001);
    check("rsp_data", rsp_data_o, exp);
  endtask : rd

  // Access to the match address, then an instruction boundary.
  task automatic access(input logic f);
    @(posedge clk_i); #2;
    cpu_access_i = 1'b1; cpu_fetch_i = f; cpu_addr_i = 16'h1234;
    @(posedge clk_i); #2;
    cpu_access_i = 1'b0; cpu_fetch_i = 1'b0; cpu_boundary_i = 1'b1;
    @(posedge clk_i); #2;
    cpu_boundary_i = 1'b0;
  endtask : access

  task automatic go();
    @(posedge clk_i); #2; resume = 1'b1;
    @(posedge clk_i); #2; resume = 1'b0;
    idle(2);
  endtask : go

  // The watchdog ends a hung run well beyond the expected hundred-odd cycles.
  initial begin
    #200us;
    miscompares++;
    give_verdict();
  end

  initial begin
    idle(20); #2; reset_n_i = 1'b1; tick_run = 1'b1;
    rd(8'hE4, 16'h0000);
    rd(8'hE2, 16'h0000);
    issue(8'hC4, 16'h00FF);
    rd(8'hE4, 16'h00B8);
    check("comm_tick", {15'h0000, comm_tick_o}, 16'h0001);
    issue(8'hC2, 16'h5AC3);
    rd(8'hE2, 16'h5AC3);
    #0 cpu_wait_stop_i = 1'b1; idle(2);
    rd(8'hE4, 16'h00BC);
    @(posedge clk_i); #2 mem_ws_fail_i = 1'b1; @(posedge clk_i); #2;
    mem_ws_fail_i = 1'b0; rd(8'hE4, 16'h00BE);
    issue(8'h90, 16'h0000);
    idle(3); #2 cpu_wait_stop_i = 1'b0; idle(2);
    rd(8'hE4, 16'h00FE);
    @(posedge clk_i); #2 mem_cmd_start_i = 1'b1; @(posedge clk_i); #2;
    mem_cmd_start_i = 1'b0; rd(8'hE4, 16'h00FC);
    issue(8'hC4, 16'h0030);
    rd(8'hE4, 16'h00F4);
    issue(8'hC2, 16'h1234);
    go();
    rd(8'hE4, 16'h00B0);
    access(1'b0);
    check("halt_req", {15'h0000, halt_req_o}, 16'h0001);
    idle(3); go();
    // Forced hit with the boundary two cycles late: armed, then request.
    @(posedge clk_i); #2 cpu_access_i = 1'b1;
    @(posedge clk_i); #2 cpu_access_i = 1'b0;
    idle(2); #2;
    check("halt_req", {15'h0000, halt_req_o}, 16'h0000);
    cpu_boundary_i = 1'b1; @(posedge clk_i); #2 cpu_boundary_i = 1'b0;
    check("halt_req", {15'h0000, halt_req_o}, 16'h0001);
    idle(3); go();
    issue(8'hC4, 16'h00A0);
    access(1'b1);
    check("tag", {15'h0000, tag_o}, 16'h0001);
    cpu_tag_exec_i = 1'b1; @(posedge clk_i); #2 cpu_tag_exec_i = 1'b0;
    check("halt_req", {15'h0000, halt_req_o}, 16'h0001);
    idle(3); go();
    issue(8'hC4, 16'h0080);
    access(1'b1);
    check("tag", {15'h0000, tag_o}, 16'h0000);
    check("halt_req", {15'h0000, halt_req_o}, 16'h0000);
    issue(8'hC4, 16'h0038);
    check("permit", {15'h0000, permit}, 16'h0000);
    check("bken", {15'h0000, bken}, 16'h0001);
    check("clk_sel", {15'h0000, comm_clock_select_o}, 16'h0001);
    issue(8'h90, 16'h0000); idle(2); #2;
    check("halt_req", {15'h0000, halt_req_o}, 16'h0000);
    // Mid-run reset, with the alternate tick held quiet as at power-up.
    reset_n_i = 1'b0; tick_run = 1'b0; idle(3); #2;
    reset_n_i = 1'b1; tick_run = 1'b1;
    rd(8'hE4, 16'h0000);
    rd(8'hE2, 16'h0000);
    check("bken", {15'h0000, bken}, 16'h0000);
    issue(8'hC4, 16'h0080);
    check("permit", {15'h0000, permit}, 16'h0001);
    give_verdict();
  end
endmodule : debug_status_breakpoint_regs_bench
